// >>> ddr_host_consts.svh
// Offsets, field positions, reset values and timing counts of the DDR host controller.
// Assumes the controller core runs at 250 MHz and drives the memory clock at half that rate.
`ifndef DDR_HOST_CONSTS_SVH
`define DDR_HOST_CONSTS_SVH

`define REG_CTRL         8'h00
`define REG_CMD          8'h04
`define REG_STATUS       8'h08
`define REG_MODE         8'h0C
`define REG_EMODE        8'h10

`define CTRL_START       0
`define CTRL_REF_EN      1
`define CMD_OP_LSB       0
`define CMD_BANK_LSB     4
`define CMD_ADDR_LSB     8
`define ST_INIT_DONE     0
`define ST_PENDING       1
`define ST_SELF_REF      2
`define ST_REF_DUE       3
`define ST_STATE_LSB     16

`define CTRL_RESET       32'h0000_0000
`define MODE_RESET       12'h032
`define EMODE_RESET      12'h000

`define AUTO_PRE_BIT     10
`define DLL_RESET_BIT    8
`define DLL_DISABLE_BIT  0
`define EXT_MODE_REG_WRITE_CMD_BANK        2'h1
`define MRS_BANK         2'h0
`define INIT_REF_COUNT   2

`define PCLK_NS          4
`define CK_NS            (2 * `PCLK_NS)
`define CK_UP(ns)        (((ns) + `CK_NS - 1) / `CK_NS)

`define T_RCD_NS         15
`define T_RP_NS          15
`define T_RFC_FAST_NS    60
`define T_RFC_SLOW_NS    70
`define T_XSNR_NS        75
`define T_RRD_FAST_CK    3
`define T_RRD_SLOW_CK    2
`define T_WR_CK          3
`define T_MRD_CK         2
`define T_XSRD_CK        200
`define T_DLL_CK         200
`define T_CCD_CK         1
`define T_REFI_US        15.6
`define T_STABLE_US      200

`define T_RCD_CK         `CK_UP(`T_RCD_NS)
`define T_RP_CK          `CK_UP(`T_RP_NS)
`define T_RFC_FAST_CK    `CK_UP(`T_RFC_FAST_NS)
`define T_RFC_SLOW_CK    `CK_UP(`T_RFC_SLOW_NS)
`define T_XSNR_CK        `CK_UP(`T_XSNR_NS)
`define T_DAL_CK         (`T_WR_CK + `T_RP_CK)
// The small offset keeps a float product such as 1949.9999 from losing a whole cycle.
`define T_REFI_CK        $rtoi(`T_REFI_US * 1000.0 / `CK_NS + 0.001)
`define T_STABLE_CK      (`T_STABLE_US * 1000 / `CK_NS)

`endif

// >>> ddr_host_pkg.sv
// Types shared by the DDR host controller files.
// Assumes commands are encoded as chip select, row strobe, column strobe, write enable.
package ddr_host_pkg;

  typedef enum logic [3:0] {
    CMD_NOP   = 4'h7,
    CMD_ACT   = 4'h3,
    CMD_READ  = 4'h5,
    CMD_WRITE = 4'h4,
    CMD_PRE   = 4'h2,
    CMD_REF   = 4'h1,
    CMD_MRS   = 4'h0
  } ddr_cmd_t;

  typedef enum logic [2:0] {
    OP_ACT      = 3'h0,
    OP_READ     = 3'h1,
    OP_WRITE    = 3'h2,
    OP_PRE      = 3'h3,
    OP_PREA     = 3'h4,
    OP_REF      = 3'h5,
    OP_SREF_IN  = 3'h6,
    OP_SREF_OUT = 3'h7
  } user_op_t;

  typedef enum logic [10:0] {
    ST_RESET   = 11'h001,
    ST_STABLE  = 11'h002,
    ST_CKE     = 11'h004,
    ST_PREA1   = 11'h008,
    ST_EXT_MODE_REG_WRITE_CMD    = 11'h010,
    ST_MRS_DLL = 11'h020,
    ST_PREA2   = 11'h040,
    ST_REF_INI = 11'h080,
    ST_MRS_OP  = 11'h100,
    ST_READY   = 11'h200,
    ST_SREF    = 11'h400
  } state_t;

endpackage

// >>> ddr_gap_timer.sv
// Countdown that spaces commands by a loaded number of memory clock ticks.
// Assumes load and tick come from logic on the same clock; load value is at least one.
`timescale 1ns/1ns
module ddr_gap_timer #(
  parameter int W = 15
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              done
);

  logic [W-1:0] count_q;

  // A load of N lets the next command go exactly N ticks later.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
    end else if (tick) begin
      if (load) begin
        count_q <= value - W'(1);
      end else if (count_q != '0) begin
        count_q <= count_q - W'(1);
      end
    end
  end

  assign done = (count_q == '0);

endmodule // ddr_gap_timer

// >>> ddr_host_ctrl.sv
// DDR memory host: power-up sequence, command spacing, periodic refresh, APB control registers.
// Assumes an APB master on pclk and a DDR device whose pins are driven straight from here.
`timescale 1ns/1ns
`include "ddr_host_consts.svh"
module ddr_host_ctrl
  import ddr_host_pkg::*;
#(
  parameter int       STABLE_CK  = `T_STABLE_CK,
  parameter bit       FAST_GRADE = 1'b1,
  parameter int       NBANK      = 4,
  parameter int       AW         = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   ddr_ck,
  output logic                   ddr_ck_n,
  output logic                   ddr_cke,
  output logic                   ddr_cs_n,
  output logic                   ddr_ras_n,
  output logic                   ddr_cas_n,
  output logic                   ddr_we_n,
  output logic [1:0]             ddr_ba,
  output logic [AW-1:0]          ddr_addr
);

  localparam logic [14:0] STABLE_LD = 15'(STABLE_CK);
  localparam logic [14:0] RP_LD     = 15'(`T_RP_CK);
  localparam logic [14:0] MRD_LD    = 15'(`T_MRD_CK);
  localparam logic [14:0] XSNR_LD   = 15'(`T_XSNR_CK);
  localparam logic [14:0] RFC_LD    = FAST_GRADE ? 15'(`T_RFC_FAST_CK) : 15'(`T_RFC_SLOW_CK);
  localparam logic [14:0] ONE_LD    = 15'(`T_CCD_CK);
  localparam logic [4:0]  RCD_LD    = 5'(`T_RCD_CK - 1);
  localparam logic [4:0]  BRP_LD    = 5'(`T_RP_CK - 1);
  localparam logic [4:0]  DAL_LD    = 5'(`T_DAL_CK - 1);
  localparam logic [4:0]  RRD_LD    = FAST_GRADE ? 5'(`T_RRD_FAST_CK - 1) : 5'(`T_RRD_SLOW_CK - 1);
  localparam logic [7:0]  XSRD_LD   = 8'(`T_XSRD_CK - 1);
  localparam logic [7:0]  DLL_LD    = 8'(`T_DLL_CK - 1);
  localparam logic [10:0] REFI_LD   = 11'(`T_REFI_CK - 1);

  state_t          st_q;
  state_t          st_d;
  ddr_cmd_t        cmd_q;
  ddr_cmd_t        cmd_d;
  logic            ck_q;
  logic            ckn_q;
  logic            cke_q;
  logic            cke_d;
  logic [1:0]      ba_q;
  logic [1:0]      ba_d;
  logic [AW-1:0]   addr_q;
  logic [AW-1:0]   addr_d;
  logic            tick;
  logic            gap_load;
  logic [14:0]     gap_val;
  logic            gap_done;
  logic [4:0]      bank_cnt_q [NBANK];
  logic [4:0]      rcd_cnt_q  [NBANK];
  logic [4:0]      rrd_q;
  logic [7:0]      xsrd_q;
  logic [7:0]      dll_q;
  logic [10:0]     refi_q;
  logic            ref_due_q;
  logic [1:0]      ref_n_q;
  logic            op_ok;
  logic            ev_act;
  logic            ev_pre;
  logic            ev_prea;
  logic            ev_wr_ap;
  logic            ev_rd_ap;
  logic            ev_ref;
  logic            ev_take;
  logic            ev_dll;
  logic            ev_xs;
  logic            ref_inc;
  logic [31:0]     ctrl_q;
  logic [AW-1:0]   mode_q;
  logic [AW-1:0]   emode_q;
  logic            pend_q;
  user_op_t        pend_op_q;
  logic [1:0]      pend_ba_q;
  logic [AW-1:0]   pend_addr_q;
  logic            wr_en;
  logic            init_done;

  function automatic logic banks_idle(input logic [4:0] cnt [NBANK]);
    logic idle;
    idle = 1'b1;
    for (int i = 0; i < NBANK; i++) begin
      idle = idle & (cnt[i] == 5'h00);
    end
    return idle;
  endfunction

  function automatic logic reg_mapped(input logic [7:0] a);
    return (a == `REG_CTRL) || (a == `REG_CMD) || (a == `REG_STATUS) ||
           (a == `REG_MODE) || (a == `REG_EMODE);
  endfunction

  // Commands change on the pclk edge where the memory clock falls, so they are settled at its next rising edge.
  assign tick      = ck_q;
  assign init_done = (st_q == ST_READY) || (st_q == ST_SREF);

  ddr_gap_timer #(
    .W       (15)
  ) u_gap (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .load    (gap_load),
    .value   (gap_val),
    .done    (gap_done)
  );

  always_comb begin
    unique case (pend_op_q)
      OP_ACT:      op_ok = (bank_cnt_q[pend_ba_q] == 5'h00) && (rrd_q == 5'h00);
      OP_READ:     op_ok = (rcd_cnt_q[pend_ba_q] == 5'h00) && (xsrd_q == 8'h00);
      OP_WRITE:    op_ok = (rcd_cnt_q[pend_ba_q] == 5'h00);
      OP_REF:      op_ok = banks_idle(bank_cnt_q);
      OP_SREF_IN:  op_ok = banks_idle(bank_cnt_q);
      OP_PRE:      op_ok = 1'b1;
      OP_PREA:     op_ok = 1'b1;
      OP_SREF_OUT: op_ok = 1'b1;
    endcase
  end

  always_comb begin
    st_d     = st_q;
    cmd_d    = CMD_NOP;
    ba_d     = 2'h0;
    addr_d   = '0;
    cke_d    = cke_q;
    gap_load = 1'b0;
    gap_val  = ONE_LD;
    ev_act   = 1'b0;
    ev_pre   = 1'b0;
    ev_prea  = 1'b0;
    ev_wr_ap = 1'b0;
    ev_rd_ap = 1'b0;
    ev_ref   = 1'b0;
    ev_take  = 1'b0;
    ev_dll   = 1'b0;
    ev_xs    = 1'b0;
    ref_inc  = 1'b0;
    if (tick) begin
      unique case (st_q)
        ST_RESET: begin
          if (ctrl_q[`CTRL_START]) begin
            gap_load = 1'b1;
            gap_val  = STABLE_LD;
            st_d     = ST_STABLE;
          end
        end
        ST_STABLE: begin
          if (gap_done) begin
            cke_d    = 1'b1;
            gap_load = 1'b1;
            st_d     = ST_CKE;
          end
        end
        ST_CKE: begin
          if (gap_done) begin
            cmd_d                 = CMD_PRE;
            addr_d[`AUTO_PRE_BIT] = 1'b1;
            ev_prea               = 1'b1;
            gap_load              = 1'b1;
            gap_val               = RP_LD;
            st_d                  = ST_PREA1;
          end
        end
        ST_PREA1: begin
          if (gap_done) begin
            cmd_d                    = CMD_MRS;
            ba_d                     = `EXT_MODE_REG_WRITE_CMD_BANK;
            addr_d                   = emode_q;
            addr_d[`DLL_DISABLE_BIT] = 1'b0;
            gap_load                 = 1'b1;
            gap_val                  = MRD_LD;
            st_d                     = ST_EXT_MODE_REG_WRITE_CMD;
          end
        end
        ST_EXT_MODE_REG_WRITE_CMD: begin
          if (gap_done) begin
            cmd_d                  = CMD_MRS;
            ba_d                   = `MRS_BANK;
            addr_d                 = mode_q;
            addr_d[`DLL_RESET_BIT] = 1'b1;
            ev_dll                 = 1'b1;
            gap_load               = 1'b1;
            gap_val                = MRD_LD;
            st_d                   = ST_MRS_DLL;
          end
        end
        ST_MRS_DLL: begin
          if (gap_done) begin
            cmd_d                 = CMD_PRE;
            addr_d[`AUTO_PRE_BIT] = 1'b1;
            ev_prea               = 1'b1;
            gap_load              = 1'b1;
            gap_val               = RP_LD;
            st_d                  = ST_PREA2;
          end
        end
        ST_PREA2: begin
          if (gap_done) begin
            cmd_d    = CMD_REF;
            ref_inc  = 1'b1;
            gap_load = 1'b1;
            gap_val  = RFC_LD;
            st_d     = ST_REF_INI;
          end
        end
        ST_REF_INI: begin
          if (gap_done) begin
            gap_load = 1'b1;
            if (ref_n_q < 2'(`INIT_REF_COUNT)) begin
              cmd_d   = CMD_REF;
              ref_inc = 1'b1;
              gap_val = RFC_LD;
            end else begin
              cmd_d                  = CMD_MRS;
              ba_d                   = `MRS_BANK;
              addr_d                 = mode_q;
              addr_d[`DLL_RESET_BIT] = 1'b0;
              gap_val                = MRD_LD;
              st_d                   = ST_MRS_OP;
            end
          end
        end
        ST_MRS_OP: begin
          if (gap_done && (dll_q == 8'h00)) begin
            st_d = ST_READY;
          end
        end
        ST_READY: begin
          if (gap_done) begin
            if (ref_due_q) begin
              if (banks_idle(bank_cnt_q)) begin
                cmd_d    = CMD_REF;
                ev_ref   = 1'b1;
                gap_load = 1'b1;
                gap_val  = RFC_LD;
              end else begin
                cmd_d                 = CMD_PRE;
                addr_d[`AUTO_PRE_BIT] = 1'b1;
                ev_prea               = 1'b1;
                gap_load              = 1'b1;
                gap_val               = RP_LD;
              end
            end else if (pend_q && op_ok) begin
              ev_take = 1'b1;
              ba_d    = pend_ba_q;
              unique case (pend_op_q)
                OP_ACT: begin
                  cmd_d  = CMD_ACT;
                  addr_d = pend_addr_q;
                  ev_act = 1'b1;
                end
                OP_READ: begin
                  cmd_d    = CMD_READ;
                  addr_d   = pend_addr_q;
                  ev_rd_ap = pend_addr_q[`AUTO_PRE_BIT];
                end
                OP_WRITE: begin
                  cmd_d    = CMD_WRITE;
                  addr_d   = pend_addr_q;
                  ev_wr_ap = pend_addr_q[`AUTO_PRE_BIT];
                end
                OP_PRE: begin
                  cmd_d  = CMD_PRE;
                  ev_pre = 1'b1;
                end
                OP_PREA: begin
                  cmd_d                 = CMD_PRE;
                  addr_d[`AUTO_PRE_BIT] = 1'b1;
                  ev_prea               = 1'b1;
                end
                OP_REF: begin
                  cmd_d    = CMD_REF;
                  ev_ref   = 1'b1;
                  gap_load = 1'b1;
                  gap_val  = RFC_LD;
                end
                OP_SREF_IN: begin
                  cmd_d = CMD_REF;
                  cke_d = 1'b0;
                  st_d  = ST_SREF;
                end
                OP_SREF_OUT: begin
                  cmd_d = CMD_NOP;
                end
              endcase
            end
          end
        end
        ST_SREF: begin
          if (pend_q && (pend_op_q == OP_SREF_OUT)) begin
            ev_take  = 1'b1;
            cke_d    = 1'b1;
            ev_xs    = 1'b1;
            gap_load = 1'b1;
            gap_val  = XSNR_LD;
            st_d     = ST_READY;
          end
        end
        default: begin
          st_d = ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_q  <= 1'b0;
      ckn_q <= 1'b1;
    end else begin
      ck_q  <= ~ck_q;
      ckn_q <= ~ckn_q;
    end
  end

  // Clock enable stays low and the bus idles on NOP until the stable wait that follows the start bit has run out.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= ST_RESET;
      cmd_q  <= CMD_NOP;
      cke_q  <= 1'b0;
      ba_q   <= 2'h0;
      addr_q <= '0;
    end else if (tick) begin
      st_q   <= st_d;
      cmd_q  <= cmd_d;
      cke_q  <= cke_d;
      ba_q   <= ba_d;
      addr_q <= addr_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NBANK; i++) begin
        bank_cnt_q[i] <= 5'h00;
        rcd_cnt_q[i]  <= 5'h00;
      end
    end else if (tick) begin
      for (int i = 0; i < NBANK; i++) begin
        if (ev_prea || (ev_pre && (pend_ba_q == 2'(i))) || (ev_rd_ap && (pend_ba_q == 2'(i)))) begin
          bank_cnt_q[i] <= BRP_LD;
        end else if (ev_wr_ap && (pend_ba_q == 2'(i))) begin
          bank_cnt_q[i] <= DAL_LD;
        end else if (bank_cnt_q[i] != 5'h00) begin
          bank_cnt_q[i] <= bank_cnt_q[i] - 5'h01;
        end
        if (ev_act && (pend_ba_q == 2'(i))) begin
          rcd_cnt_q[i] <= RCD_LD;
        end else if (rcd_cnt_q[i] != 5'h00) begin
          rcd_cnt_q[i] <= rcd_cnt_q[i] - 5'h01;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rrd_q  <= 5'h00;
      xsrd_q <= 8'h00;
      dll_q  <= 8'h00;
    end else if (tick) begin
      if (ev_act) begin
        rrd_q <= RRD_LD;
      end else if (rrd_q != 5'h00) begin
        rrd_q <= rrd_q - 5'h01;
      end
      if (ev_xs) begin
        xsrd_q <= XSRD_LD;
      end else if (xsrd_q != 8'h00) begin
        xsrd_q <= xsrd_q - 8'h01;
      end
      if (ev_dll) begin
        dll_q <= DLL_LD;
      end else if (dll_q != 8'h00) begin
        dll_q <= dll_q - 8'h01;
      end
    end
  end

  // The interval restarts after self refresh, since the device kept itself refreshed meanwhile.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refi_q    <= REFI_LD;
      ref_due_q <= 1'b0;
      ref_n_q   <= 2'h0;
    end else if (tick) begin
      if (ref_inc) begin
        ref_n_q <= ref_n_q + 2'h1;
      end
      if ((st_q != ST_READY) || !ctrl_q[`CTRL_REF_EN]) begin
        refi_q <= REFI_LD;
      end else if (refi_q == 11'h000) begin
        refi_q <= REFI_LD;
      end else begin
        refi_q <= refi_q - 11'h001;
      end
      if ((st_q == ST_READY) && ctrl_q[`CTRL_REF_EN] && (refi_q == 11'h000)) begin
        ref_due_q <= 1'b1;
      end else if (ev_ref) begin
        ref_due_q <= 1'b0;
      end
    end
  end

  assign wr_en = psel && penable && pwrite && pready && !pslverr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      pslverr <= !reg_mapped(paddr);
      prdata  <= 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          `REG_CTRL:   prdata <= ctrl_q;
          `REG_MODE:   prdata <= {20'h0_0000, mode_q};
          `REG_EMODE:  prdata <= {20'h0_0000, emode_q};
          `REG_STATUS: prdata <= {5'h00, st_q, 12'h000, ref_due_q, (st_q == ST_SREF), pend_q, init_done};
          default:     prdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // A command written while one is still pending is dropped; software polls the pending bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q      <= `CTRL_RESET;
      mode_q      <= `MODE_RESET;
      emode_q     <= `EMODE_RESET;
      pend_q      <= 1'b0;
      pend_op_q   <= OP_ACT;
      pend_ba_q   <= 2'h0;
      pend_addr_q <= '0;
    end else begin
      if (wr_en && (paddr == `REG_CTRL)) begin
        ctrl_q <= pwdata & 32'h0000_0003;
      end
      if (wr_en && (paddr == `REG_MODE)) begin
        mode_q <= pwdata[AW-1:0];
      end
      if (wr_en && (paddr == `REG_EMODE)) begin
        emode_q <= pwdata[AW-1:0];
      end
      if (wr_en && (paddr == `REG_CMD) && !pend_q) begin
        pend_q      <= 1'b1;
        pend_op_q   <= user_op_t'(pwdata[`CMD_OP_LSB +: 3]);
        pend_ba_q   <= pwdata[`CMD_BANK_LSB +: 2];
        pend_addr_q <= pwdata[`CMD_ADDR_LSB +: AW];
      end else if (ev_take) begin
        pend_q <= 1'b0;
      end
    end
  end

  assign ddr_ck    = ck_q;
  assign ddr_ck_n  = ckn_q;
  assign ddr_cke   = cke_q;
  assign ddr_cs_n  = cmd_q[3];
  assign ddr_ras_n = cmd_q[2];
  assign ddr_cas_n = cmd_q[1];
  assign ddr_we_n  = cmd_q[0];
  assign ddr_ba    = ba_q;
  assign ddr_addr  = addr_q;

endmodule // ddr_host_ctrl

// >>> ddr_host_ctrl_chk.sv
// Concurrent checks on the APB side and memory pins of the DDR host.
// Assumes it is bound into every ddr_host_ctrl instance.
`timescale 1ns/1ns
module ddr_host_ctrl_chk
  import ddr_host_pkg::*;
#(
  parameter int AW = 12
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          ddr_ck,
  input wire logic          ddr_ck_n,
  input wire logic          ddr_cke,
  input wire logic          ddr_cs_n,
  input wire logic          ddr_ras_n,
  input wire logic          ddr_cas_n,
  input wire logic          ddr_we_n,
  input wire logic [1:0]    ddr_ba,
  input wire logic [AW-1:0] ddr_addr
);
  wire logic [3:0] c   = {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n};
  // The device takes the command at the edge where the memory clock rises.
  wire logic       k   = !ddr_ck && ddr_cke;
  wire logic       nop = c == CMD_NOP;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready) else $error("bad ready pulse");
  apb_err_a: assert property (pready |-> pslverr == (paddr > 8'h10 || paddr[1:0] != 2'h0)) else $error("bad error");
  ck_pair_a: assert property (ddr_ck_n == !ddr_ck) else $error("clock pair not complementary");
  cke_nop_a: assert property (!ddr_cke [*3] |-> nop) else $error("command with clock enable low");
  cmd_grid_a: assert property ($changed(c) |-> !ddr_ck && $past(ddr_ck)) else $error("command off grid");
  mode_gap_a: assert property (k && c == CMD_MRS |-> ##2 nop [*2]) else $error("mode write gap short");
  act_col_a: assert property (k && c == CMD_ACT |-> ##2 !(c[3:1] == 3'h2 && ddr_ba == $past(ddr_ba, 2)))
    else $error("column too soon");
  act_act_a: assert property (k && c == CMD_ACT |-> ##2 (c != CMD_ACT) [*4]) else $error("activates too close");
  ref_gap_a: assert property (k && c == CMD_REF |-> ##2 nop [*7] ##1 nop [*7]) else $error("refresh gap short");
  cover property (k && c == CMD_MRS);
  cover property (k && c == CMD_ACT);
  cover property (pready && pslverr);
endmodule // ddr_host_ctrl_chk

bind ddr_host_ctrl ddr_host_ctrl_chk #(.AW(AW)) i_chk (.*);

// >>> ddr_dev_model.sv
// Behavioural DDR device: samples the command pins at each memory clock rise and counts spacing faults.
// Assumes the host drives every pin; STABLE matches the host's power-up wait.
`timescale 1ns/1ns
`include "ddr_host_consts.svh"
module ddr_dev_model
  import ddr_host_pkg::*;
#(
  parameter int STABLE = 20
) (
  input  wire logic        ck,
  input  wire logic        cke,
  input  wire logic [3:0]  cmd,
  input  wire logic [1:0]  ba,
  input  wire logic [11:0] addr,
  output int               err
);
  int t, low, act, nxt, rd, lref, nref;
  int row[4];
  int col[4];
  bit up, ckq;
  always @(posedge ck) begin
    t = t + 1;
    if (!cke) low = low + 1;
    if (!cke && cmd != CMD_NOP && cmd != CMD_REF) err++;
    if (cke && !ckq) begin
      if (!up && low < STABLE) err++;
      if (up) nxt = t + `T_XSNR_CK;
      if (up) rd = t + `T_XSRD_CK;
      up = 1;
    end
    ckq = cke;
    if (cke && !cmd[3] && cmd != CMD_NOP) begin
      if (t < nxt) err++;
      case (cmd)
        CMD_ACT: begin
          if (t < act || t < row[ba]) err++;
          act = t + `T_RRD_FAST_CK;
          col[ba] = t + `T_RCD_CK;
        end
        CMD_READ, CMD_WRITE: begin
          // Back-to-back columns are accepted; only the row and lock waits count.
          if (t < col[ba] || (cmd == CMD_READ && t < rd)) err++;
          if (addr[10]) row[ba] = t + (cmd == CMD_WRITE ? `T_DAL_CK : `T_RP_CK);
        end
        CMD_PRE: for (int i = 0; i < 4; i++) if (addr[10] || i == ba) row[i] = t + `T_RP_CK;
        CMD_REF: begin
          // The first gaps after power-up and the manual refresh are not periodic.
          if (nref > 3 && t - lref > `T_REFI_CK + 16) err++;
          nref++;
          lref = t;
          nxt = t + `T_RFC_FAST_CK;
        end
        CMD_MRS: begin
          nxt = t + `T_MRD_CK;
          if (ba == `MRS_BANK && addr[`DLL_RESET_BIT]) rd = t + `T_DLL_CK;
        end
        default: ;
      endcase
    end
  end
endmodule // ddr_dev_model

// >>> ddr_host_ctrl_tb.sv
// Self-checking bench for the DDR host: registers, power-up order, command issue, refresh.
// Assumes the device model on the memory pins and the checker bound into the host.
`timescale 1ns/1ns
`include "ddr_host_consts.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module ddr_host_ctrl_tb
  import ddr_host_pkg::*;
;
  localparam logic [32:0] W = 33'h1_0000_0000;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat, r32, ec, seed = 32'h59;
  logic        pready, pslverr, ddr_ck, ddr_ck_n, ddr_cke, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n;
  logic [1:0]  ddr_ba, b;
  logic [11:0] ddr_addr, md, em, rw, cl;
  logic [32:0] aq[$], am[$], v, m;
  logic [31:0] cq[$];
  int          fail_count, comparisons, cyc, err;
  wire logic [3:0] c = {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n};
  always #2 pclk = ~pclk;
  ddr_host_ctrl #(.STABLE_CK(20)) i_dut (.*);
  ddr_dev_model #(.STABLE(20)) i_mem (.ck(ddr_ck), .cke(ddr_cke), .cmd(c), .ba(ddr_ba), .addr(ddr_addr), .err);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic void ex(ddr_cmd_t k, logic [13:0] mk, logic [13:0] val);
    cq.push_back({mk, k, val & mk});
  endfunction
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e, mk);
    aq.push_back(e & mk);
    am.push_back(mk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic idle(input int bit_no);
    do apb(1'b0, `REG_STATUS, 0, 0, W); while (rdat[bit_no] !== (bit_no == `ST_INIT_DONE));
  endtask
  // A command written while one is pending would be dropped, so wait for the slot first.
  task automatic issue(input user_op_t op, input logic [13:0] val, input ddr_cmd_t k, input logic [13:0] mk);
    idle(`ST_PENDING);
    if (k != CMD_NOP) ex(k, mk, val);
    apb(1'b1, `REG_CMD, {12'h0, val[11:0], 2'h0, val[13:12], 1'b0, op}, 0, W);
  endtask
  always @(posedge pclk) if (psel && penable && pready) begin
    v = aq.size() ? aq.pop_front() : '1;
    m = am.size() ? am.pop_front() : '1;
    `CHK({pslverr, prdata} & m, v)
  end
  always @(posedge ddr_ck) if (!ddr_cs_n && c != CMD_NOP) begin
    ec = cq.size() ? cq.pop_front() : '1;
    `CHK({c, {ddr_ba, ddr_addr} & ec[31:18]}, ec[17:0])
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin `CHK(cyc, 0) summarize(); end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `REG_CTRL, 0, 0, '1);
    apb(1'b0, `REG_MODE, 0, {21'h0, `MODE_RESET}, '1);
    apb(1'b0, `REG_EMODE, 0, 0, '1);
    apb(1'b0, `REG_STATUS, 0, 33'h0_0001_0000, 33'h1_07FF_000F);
    apb(1'b0, 8'h14, 0, W, '1);
    apb(1'b1, 8'h20, 32'hFFFF_FFFF, W, W);
    r32 = rnd();
    md = r32[11:0];
    em = r32[23:12];
    apb(1'b1, `REG_MODE, {20'h0, md}, 0, W);
    apb(1'b1, `REG_EMODE, {20'h0, em}, 0, W);
    apb(1'b0, `REG_MODE, 0, {21'h0, md}, '1);
    $display("register test finished");
    ex(CMD_PRE, 14'h0400, 14'h0400);
    ex(CMD_MRS, '1, {2'h1, em & 12'hFFE});
    ex(CMD_MRS, '1, {2'h0, md | 12'h100});
    ex(CMD_PRE, 14'h0400, 14'h0400);
    ex(CMD_REF, 0, 0);
    ex(CMD_REF, 0, 0);
    ex(CMD_MRS, '1, {2'h0, md & 12'hEFF});
    apb(1'b1, `REG_CTRL, 32'h1, 0, W);
    idle(`ST_INIT_DONE);
    $display("power-up test finished");
    r32 = rnd();
    b = r32[1:0];
    rw = r32[13:2];
    cl = r32[25:14] & 12'hBFF;
    issue(OP_ACT, {b, rw}, CMD_ACT, '1);
    issue(OP_ACT, {~b, rw}, CMD_ACT, '1);
    issue(OP_READ, {b, cl}, CMD_READ, '1);
    issue(OP_WRITE, {~b, cl | 12'h400}, CMD_WRITE, '1);
    issue(OP_ACT, {~b, rw}, CMD_ACT, '1);
    issue(OP_PRE, {b, 12'h0}, CMD_PRE, 14'h3400);
    issue(OP_PREA, 14'h0400, CMD_PRE, 14'h0400);
    issue(OP_REF, 0, CMD_REF, 0);
    issue(OP_SREF_IN, 0, CMD_REF, 0);
    idle(`ST_PENDING);
    apb(1'b0, `REG_STATUS, 0, 33'h4, 33'h4);
    issue(OP_SREF_OUT, 0, CMD_NOP, 0);
    issue(OP_ACT, {b, rw}, CMD_ACT, '1);
    issue(OP_READ, {b, cl | 12'h400}, CMD_READ, '1);
    issue(OP_PREA, 14'h0400, CMD_PRE, 14'h0400);
    $display("command test finished");
    ex(CMD_REF, 0, 0);
    ex(CMD_REF, 0, 0);
    apb(1'b1, `REG_CTRL, 32'h3, 0, W);
    while (cq.size() != 0) @(posedge pclk);
    $display("refresh test finished");
    `CHK(err, 0)
    summarize();
  end
endmodule // ddr_host_ctrl_tb
